// ==== common/uart_rx_pkg.sv ====
// Summary of operation
// - Invert input on request; receive only when enabled
// - Frame: start zero, 8/9 data lsb first, stops
// - Completed character loads empty buffer, sets full flag
// - Full buffer on completion: overrun, character discarded
// - Sixteen-times sampling; three ones then zero is edge
// - Start accepted when two of slots 3/5/7 low
// - Bit value is majority of slots 8/9/10
// - Any disagreeing sample in frame sets noise flag
// - Every falling edge outside the start bit realigns the bit sample counter
// - Non-break framing error preloads edge history with ones
// - Framing flag set blocks transfers into the buffer
// - Sleep suppresses receive flags except optional idle flag
// - Idle wakeup after 10, 11 or 12 idle bits
// - Waking idle sets idle flag only if enabled
// - Idle counting starts after start or after stop
// - Address mark msb clears sleep (two stops: bit before msb also one); character is received
// - Three masked request outputs: transmit, receive, error
// - Transmit empty and complete request when enabled
// - Status read then data read clears full flag
// - Idle flag clears likewise; rearms after new character
// - Error flags set with full flag, never on overrun
// - Enabled receiver sets edge flag; write one clears
// - Sampling rate derived from the bus clock
package uart_rx_pkg;

	// Divider and sampling
	localparam int        DIV_W       = 13;          // Width of bus-clock divider
	localparam logic [4:0] SLOT_FIRST = 5'h01;       // Slot of the edge sample
	localparam logic [4:0] SLOT_THREE = 5'h03;
	localparam logic [4:0] SLOT_FIVE  = 5'h05;
	localparam logic [4:0] SLOT_SEVEN = 5'h07;
	localparam logic [4:0] SLOT_EIGHT = 5'h08;
	localparam logic [4:0] SLOT_NINE  = 5'h09;
	localparam logic [4:0] SLOT_TEN   = 5'h0a;
	localparam logic [4:0] SLOT_LAST  = 5'h10;       // Sixteenth slot ends a bit
	localparam logic [2:0] HIST_ONES  = 3'h7;        // Three high samples

	// Frame shape
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	localparam logic [3:0] CHAR_BASE   = 4'ha;       // Start + 8 data + 1 stop

	// Receiver states
	typedef enum logic [2:0] {
		ST_HUNT  = 3'b001,                       // Searching for falling edge
		ST_START = 3'b010,                       // Checking start bit
		ST_BITS  = 3'b100                        // Data and stop bits
	} rx_state_t;

endpackage : uart_rx_pkg

// ==== design/uart_receiver_wakeup_flags.sv ====
`timescale 1ns/1ns
module uart_receiver_wakeup_flags
	import uart_rx_pkg::*;
#(
	parameter int DIVW = DIV_W
)(
	input  wire logic            clock,
	input  wire logic            rst_b,
	input  wire logic            rx_pin,             // Serial receive line
	input  wire logic [DIVW-1:0] baud_div,           // Bus cycles per sample tick
	input  wire logic            receiver_on,
	input  wire logic            rx_input_invert,
	input  wire logic            nine_bit_mode,
	input  wire logic            stop_bit_count_select,
	input  wire logic            parity_enable,
	input  wire logic            parity_odd,
	input  wire logic            idle_count_type,
	input  wire logic            wake_method,        // 0 idle line, 1 address mark
	input  wire logic            idle_flag_in_sleep,
	input  wire logic            sleep_write,        // Software write of sleep bit
	input  wire logic            sleep_wdata,
	input  wire logic            status_read,        // Status register read pulse
	input  wire logic            data_read,          // Data register read pulse
	input  wire logic            edge_flag_clear,    // Write one to edge flag
	input  wire logic            tx_empty_flag,
	input  wire logic            tx_complete_flag,
	input  wire logic            break_detect_flag,
	input  wire logic            tx_empty_irq_enable,
	input  wire logic            tx_complete_irq_enable,
	input  wire logic            rx_full_irq_enable,
	input  wire logic            idle_irq_enable,
	input  wire logic            edge_irq_enable,
	input  wire logic            break_irq_enable,
	input  wire logic            overrun_irq_enable,
	input  wire logic            noise_irq_enable,
	input  wire logic            framing_irq_enable,
	input  wire logic            parity_irq_enable,
	output logic [8:0]           rx_data,
	output logic                 rx_full_flag,
	output logic                 idle_flag,
	output logic                 overrun_flag,
	output logic                 noise_flag,
	output logic                 framing_error_flag,
	output logic                 parity_error_flag,
	output logic                 rx_edge_flag,
	output logic                 rx_sleep,
	output logic                 tx_irq,
	output logic                 rx_irq,
	output logic                 err_irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Two-of-three vote
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction : maj3

	// ----------------------------------------
	// Receiver state
	// ----------------------------------------

	rx_state_t       st_q, st_d;           // Receiver state
	logic [DIVW-1:0] div_q, div_d;         // Sample tick divider
	logic [2:0]      hist_q, hist_d;       // Edge search history
	logic [4:0]      rt_q, rt_d;           // Slot within bit time
	logic [3:0]      bit_q, bit_d;         // 0 start, then data, then stops
	logic [2:0]      vote_q, vote_d;       // Held samples for voting
	logic [8:0]      sh_q, sh_d;           // Assembled data bits
	logic            nz_q, nz_d;           // Noise seen this frame
	logic            fe_q, fe_d;           // Stop bit low this frame
	logic            prev_q, prev_d;       // Last decided data bit
	logic [7:0]      icnt_q, icnt_d;       // Idle sample counter
	logic            lvl_q, lvl_d;         // Line level last clock
	logic            tick;                 // Sixteen-times sample enable
	logic            s;                    // Sampled, optionally inverted line
	logic            edge_seen;            // Falling edge on this tick
	logic            done;                 // Frame finished this cycle
	logic            wake_mark;            // Address mark seen in sleep
	logic            idle_hit;             // Full idle character reached
	logic            perr;                 // Parity mismatch of frame
	logic            v;                    // Decided bit value
	logic [3:0]      ndata;                // Data bits per frame
	logic [3:0]      lastbit;              // Index of last stop bit
	logic [7:0]      itarget;              // Idle samples per character
	logic            icount_ok;            // Idle counting permitted

	// Next-state logic for the receive path
	always_comb begin
		st_d      = st_q;
		div_d     = div_q;
		hist_d    = hist_q;
		rt_d      = rt_q;
		bit_d     = bit_q;
		vote_d    = vote_q;
		sh_d      = sh_q;
		nz_d      = nz_q;
		fe_d      = fe_q;
		prev_d    = prev_q;
		icnt_d    = icnt_q;
		done      = 1'b0;
		wake_mark = 1'b0;
		idle_hit  = 1'b0;
		perr      = 1'b0;
		v         = 1'b0;
		tick      = 1'b0;
		s         = rx_pin ^ rx_input_invert;
		lvl_d     = s;
		ndata     = nine_bit_mode ? DATA_BITS_9 : DATA_BITS_8;
		lastbit   = ndata + {3'h0, stop_bit_count_select} + 4'h1;
		itarget   = {CHAR_BASE + {3'h0, nine_bit_mode}
			+ {3'h0, stop_bit_count_select}, 4'h0};
		icount_ok = (st_q != ST_START) && (!idle_count_type || st_q == ST_HUNT);
		edge_seen = 1'b0;
		if (!receiver_on) begin
			// Disabled receiver returns to hunt with divider, history and idle count cleared
			st_d   = ST_HUNT;
			div_d  = '0;
			hist_d = 3'h0;
			icnt_d = 8'h00;
		end else begin
			// Bus-clock divider gives the sample tick
			if (baud_div == '0 || div_q >= baud_div - DIVW'(1)) begin
				div_d = '0;
				tick  = 1'b1;
			end else begin
				div_d = div_q + DIVW'(1);
			end
		end
		if (tick) begin
			hist_d    = {hist_q[1:0], s};
			edge_seen = (hist_q == HIST_ONES) && !s;
			// Idle line counter, saturating at one character
			if (!s || !icount_ok) begin
				icnt_d = 8'h00;
			end else if (icnt_q != itarget) begin
				icnt_d   = icnt_q + 8'h01;
				idle_hit = (icnt_q == itarget - 8'h01);
			end
			case (st_q)
				ST_HUNT: begin
					// Falling edge opens a candidate start bit
					if (edge_seen) begin
						st_d  = ST_START;
						rt_d  = SLOT_FIRST;
						bit_d = 4'h0;
						nz_d  = 1'b0;
						fe_d  = 1'b0;
						sh_d  = 9'h000;
					end
				end
				ST_START: begin
					rt_d = rt_q + 5'h01;
					if (rt_d == SLOT_THREE) begin
						vote_d[0] = s;
					end else if (rt_d == SLOT_FIVE) begin
						vote_d[1] = s;
					end else if (rt_d == SLOT_SEVEN) begin
						// Verdict from slots three, five and seven
						if (maj3(vote_q[0], vote_q[1], s)) begin
							st_d = ST_HUNT;
						end else if (vote_q[0] | vote_q[1] | s) begin
							nz_d = 1'b1;
						end
					end else if (rt_d >= SLOT_EIGHT && rt_d <= SLOT_TEN) begin
						// Start level already decided; high here is noise
						if (s) begin
							nz_d = 1'b1;
						end
					end else if (rt_d == SLOT_LAST) begin
						st_d  = ST_BITS;
						rt_d  = 5'h00;
						bit_d = 4'h1;
					end
				end
				ST_BITS: begin
					rt_d = rt_q + 5'h01;
					if (edge_seen) begin
						rt_d = SLOT_FIRST;
					end
					if (rt_d == SLOT_EIGHT) begin
						vote_d[0] = s;
					end else if (rt_d == SLOT_NINE) begin
						vote_d[1] = s;
					end else if (rt_d == SLOT_TEN) begin
						v = maj3(vote_q[0], vote_q[1], s);
						if (vote_q[0] != v || vote_q[1] != v || s != v) begin
							nz_d = 1'b1;
						end
						if (bit_q <= ndata) begin
							// Data bits arrive lsb first
							sh_d[bit_q - 4'h1] = v;
							prev_d = v;
							if (bit_q == ndata && v && wake_method
								&& rx_sleep && (!stop_bit_count_select || prev_q)) begin
								wake_mark = 1'b1;
							end
						end else begin
							if (!v) begin
								fe_d = 1'b1;
							end
							if (bit_q == lastbit) begin
								// Frame ends at mid last stop bit
								done = 1'b1;
								st_d = ST_HUNT;
								perr = parity_enable
									&& ((^(sh_d & (nine_bit_mode ? 9'h1ff : 9'h0ff)))
									!= parity_odd);
								if (fe_d && sh_d != 9'h000) begin
									hist_d = HIST_ONES;
								end
							end
						end
					end else if (rt_d == SLOT_LAST) begin
						rt_d  = 5'h00;
						bit_d = bit_q + 4'h1;
					end
				end
				default: begin
					st_d = ST_HUNT;
				end
			endcase
		end
	end

	// Receive path registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_q   <= ST_HUNT;
			div_q  <= '0;
			hist_q <= 3'h0;
			rt_q   <= 5'h00;
			bit_q  <= 4'h0;
			vote_q <= 3'h0;
			sh_q   <= 9'h000;
			nz_q   <= 1'b0;
			fe_q   <= 1'b0;
			prev_q <= 1'b0;
			icnt_q <= 8'h00;
			lvl_q  <= 1'b1;
		end else begin
			st_q   <= st_d;
			div_q  <= div_d;
			hist_q <= hist_d;
			rt_q   <= rt_d;
			bit_q  <= bit_d;
			vote_q <= vote_d;
			sh_q   <= sh_d;
			nz_q   <= nz_d;
			fe_q   <= fe_d;
			prev_q <= prev_d;
			icnt_q <= icnt_d;
			lvl_q  <= lvl_d;
		end
	end

	// ----------------------------------------
	// Status flags and sleep
	// ----------------------------------------

	logic [8:0] data_d;                    // Next buffered character
	logic       full_d, idle_d, ovr_d, nf_d, fef_d, pf_d, edge_d, sleep_d;
	logic       armed_q, armed_d;          // Status read seen, awaiting data read
	logic       iallow_q, iallow_d;        // Idle flag may set again
	logic       clr_go;                    // Read sequence completes
	logic       accept;                    // Completed frame eligible
	logic       load;                      // Character enters buffer
	logic       idle_set;                  // Idle flag sets now

	// Next values for flags
	always_comb begin
		clr_go   = data_read && armed_q;
		armed_d  = status_read ? 1'b1 : (data_read ? 1'b0 : armed_q);
		accept   = done && !rx_sleep && !framing_error_flag;
		load     = accept && !rx_full_flag;
		idle_set = idle_hit && iallow_q
			&& (!rx_sleep || idle_flag_in_sleep);
		data_d   = load ? sh_d : rx_data;
		// Hardware sets win over a clearing read
		full_d   = load | (rx_full_flag & ~clr_go);
		ovr_d    = (accept && rx_full_flag) | (overrun_flag & ~clr_go);
		nf_d     = (load && nz_d) | (noise_flag & ~clr_go);
		fef_d    = (load && fe_d) | (framing_error_flag & ~clr_go);
		pf_d     = (load && perr) | (parity_error_flag & ~clr_go);
		idle_d   = idle_set | (idle_flag & ~clr_go);
		iallow_d = load ? 1'b1 : (idle_set ? 1'b0 : iallow_q);
		// Falling edge of line while enabled and awake
		edge_d   = (receiver_on && !rx_sleep && lvl_q && !lvl_d)
			| (rx_edge_flag & ~edge_flag_clear);
		// Software write first, then automatic wakeups
		if (sleep_write) begin
			sleep_d = sleep_wdata;
		end else if (wake_mark || (idle_hit && !wake_method && rx_sleep)) begin
			sleep_d = 1'b0;
		end else begin
			sleep_d = rx_sleep;
		end
	end

	// Flag registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_data            <= 9'h000;
			rx_full_flag       <= 1'b0;
			idle_flag          <= 1'b0;
			overrun_flag       <= 1'b0;
			noise_flag         <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			rx_edge_flag       <= 1'b0;
			rx_sleep           <= 1'b0;
			armed_q            <= 1'b0;
			iallow_q           <= 1'b1;
		end else begin
			rx_data            <= data_d;
			rx_full_flag       <= full_d;
			idle_flag          <= idle_d;
			overrun_flag       <= ovr_d;
			noise_flag         <= nf_d;
			framing_error_flag <= fef_d;
			parity_error_flag  <= pf_d;
			rx_edge_flag       <= edge_d;
			rx_sleep           <= sleep_d;
			armed_q            <= armed_d;
			iallow_q           <= iallow_d;
		end
	end

	// ----------------------------------------
	// Request outputs
	// ----------------------------------------

	// Masked request groups
	assign tx_irq = (tx_empty_flag & tx_empty_irq_enable)
		| (tx_complete_flag & tx_complete_irq_enable);
	assign rx_irq = (rx_full_flag & rx_full_irq_enable)
		| (idle_flag & idle_irq_enable)
		| (rx_edge_flag & edge_irq_enable)
		| (break_detect_flag & break_irq_enable);
	assign err_irq = (overrun_flag & overrun_irq_enable)
		| (noise_flag & noise_irq_enable)
		| (framing_error_flag & framing_irq_enable)
		| (parity_error_flag & parity_irq_enable);

endmodule : uart_receiver_wakeup_flags

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
// --------------
// Receiver bench
// --------------
module tb_top
	import uart_rx_pkg::*;
;
	logic             clock = 1'b0;
	logic             rst_b, rx_pin, receiver_on, rx_input_invert, nine_bit_mode;
	logic             stop_bit_count_select, parity_enable, parity_odd, idle_count_type;
	logic             wake_method, idle_flag_in_sleep, sleep_write, sleep_wdata;
	logic             status_read, data_read, edge_flag_clear, tx_empty_flag;
	logic             tx_complete_flag, break_detect_flag, tx_empty_irq_enable;
	logic             tx_complete_irq_enable, rx_full_irq_enable, idle_irq_enable;
	logic             edge_irq_enable, break_irq_enable, overrun_irq_enable;
	logic             noise_irq_enable, framing_irq_enable, parity_irq_enable;
	logic [DIV_W-1:0] baud_div;
	logic [8:0]       rx_data;
	logic             rx_full_flag, idle_flag, overrun_flag, noise_flag, framing_error_flag;
	logic             parity_error_flag, rx_edge_flag, rx_sleep, tx_irq, rx_irq, err_irq;
	int               fail_count = 0, check_count = 0, cycles = 0;

	uart_receiver_wakeup_flags i_dut (.clock, .rst_b, .rx_pin, .baud_div, .receiver_on,
		.rx_input_invert, .nine_bit_mode, .stop_bit_count_select, .parity_enable, .parity_odd,
		.idle_count_type, .wake_method, .idle_flag_in_sleep, .sleep_write, .sleep_wdata,
		.status_read, .data_read, .edge_flag_clear, .tx_empty_flag, .tx_complete_flag,
		.break_detect_flag, .tx_empty_irq_enable, .tx_complete_irq_enable, .rx_full_irq_enable,
		.idle_irq_enable, .edge_irq_enable, .break_irq_enable, .overrun_irq_enable,
		.noise_irq_enable, .framing_irq_enable, .parity_irq_enable, .rx_data, .rx_full_flag,
		.idle_flag, .overrun_flag, .noise_flag, .framing_error_flag, .parity_error_flag,
		.rx_edge_flag, .rx_sleep, .tx_irq, .rx_irq, .err_irq);
	uart_tx_model i_tx (.clock, .invert(rx_input_invert), .line(rx_pin));

	// Clock and hang guard
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_flag
	// Waits n edges, then drives just after
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	// Status read then data read
	task automatic read_clear();
		status_read = 1'b1;
		step(1);
		status_read = 1'b0;
		data_read = 1'b1;
		step(1);
		data_read = 1'b0;
	endtask : read_clear
	task automatic go_sleep();
		sleep_write = 1'b1;
		sleep_wdata = 1'b1;
		step(1);
		sleep_write = 1'b0;
	endtask : go_sleep
	// Frame with settle time for flags
	task automatic frame(input logic [8:0] d, input int nb, input int ns, input logic sv,
		input int g);
		i_tx.send(d, nb, ns, sv, g);
		step(2);
	endtask : frame

	// Scenarios
	task automatic t_basic();
		rx_input_invert = 1'b1;
		frame(9'h0a5, 8, 1, 1'b1, -1);
		chk_flag(rx_full_flag, 1'b1);
		chk_data(rx_data, 9'h0a5);
		chk_flag(noise_flag, 1'b0);
		chk_flag(err_irq, 1'b0);
		chk_flag(rx_edge_flag, 1'b1);
		chk_flag(rx_irq, 1'b1);
		edge_flag_clear = 1'b1;
		step(1);
		edge_flag_clear = 1'b0;
		step(1);
		chk_flag(rx_edge_flag, 1'b0);
		step(200);
		chk_flag(idle_flag, 1'b1);
		read_clear();
		chk_flag(rx_full_flag, 1'b0);
		chk_flag(idle_flag, 1'b0);
		step(200);
		chk_flag(idle_flag, 1'b0);
		rx_input_invert = 1'b0;
		$display("basic done");
	endtask : t_basic
	task automatic t_overrun();
		frame(9'h03c, 8, 1, 1'b1, -1);
		frame(9'h0c3, 8, 1, 1'b1, -1);
		chk_flag(overrun_flag, 1'b1);
		chk_data(rx_data, 9'h03c);
		read_clear();
		chk_flag(overrun_flag, 1'b0);
		$display("overrun done");
	endtask : t_overrun
	task automatic t_break();
		frame(9'h000, 8, 1, 1'b0, -1);
		chk_flag(framing_error_flag, 1'b1);
		chk_flag(err_irq, 1'b1);
		frame(9'h066, 8, 1, 1'b1, -1);
		step(200);
		chk_data(rx_data, 9'h000);
		chk_flag(overrun_flag, 1'b0);
		read_clear();
		chk_flag(framing_error_flag, 1'b0);
		$display("break done");
	endtask : t_break
	task automatic t_preload();
		frame(9'h055, 8, 1, 1'b0, -1);
		step(20);
		read_clear();
		step(200);
		chk_flag(rx_full_flag, 1'b1);
		chk_data(rx_data, 9'h0ff);
		read_clear();
		$display("preload done");
	endtask : t_preload
	task automatic t_nine_noise();
		{nine_bit_mode, stop_bit_count_select, parity_enable} = 3'h7;
		frame(9'h1a5, 9, 2, 1'b1, -1);
		chk_data(rx_data, 9'h1a5);
		chk_flag(parity_error_flag, 1'b1);
		read_clear();
		parity_odd = 1'b1;
		frame(9'h1a5, 9, 2, 1'b1, -1);
		chk_data(rx_data, 9'h1a5);
		chk_flag(parity_error_flag, 1'b0);
		read_clear();
		{nine_bit_mode, stop_bit_count_select, parity_enable, parity_odd} = 4'h0;
		frame(9'h05a, 8, 1, 1'b1, 57);
		chk_data(rx_data, 9'h05a);
		chk_flag(noise_flag, 1'b1);
		chk_flag(parity_error_flag, 1'b0);
		read_clear();
		$display("nine and noise done");
	endtask : t_nine_noise
	task automatic t_sleep();
		int n;
		n = 0;
		idle_count_type = 1'b1;
		go_sleep();
		frame(9'h000, 8, 1, 1'b1, -1);
		chk_flag(rx_full_flag, 1'b0);
		while (rx_sleep === 1'b1 && n < 400) begin
			step(1);
			n++;
		end
		chk_flag(n >= 145 && n <= 175, 1'b1);
		chk_flag(idle_flag, 1'b0);
		frame(9'h011, 8, 1, 1'b1, -1);
		chk_data(rx_data, 9'h011);
		read_clear();
		wake_method = 1'b1;
		go_sleep();
		frame(9'h005, 8, 1, 1'b1, -1);
		chk_flag(rx_sleep, 1'b1);
		chk_flag(rx_full_flag, 1'b0);
		frame(9'h085, 8, 1, 1'b1, -1);
		chk_flag(rx_sleep, 1'b0);
		chk_data(rx_data, 9'h085);
		read_clear();
		// Idle flag allowed in sleep; address-mark mode keeps sleeping
		idle_flag_in_sleep = 1'b1;
		go_sleep();
		step(200);
		chk_flag(idle_flag, 1'b1);
		chk_flag(rx_sleep, 1'b1);
		sleep_write = 1'b1;
		sleep_wdata = 1'b0;
		step(1);
		sleep_write = 1'b0;
		idle_flag_in_sleep = 1'b0;
		read_clear();
		wake_method = 1'b0;
		$display("sleep done");
	endtask : t_sleep
	task automatic t_off();
		receiver_on = 1'b0;
		tx_empty_flag = 1'b1;
		edge_flag_clear = 1'b1;
		step(1);
		edge_flag_clear = 1'b0;
		chk_flag(tx_irq, 1'b1);
		tx_empty_irq_enable = 1'b0;
		frame(9'h033, 8, 1, 1'b1, -1);
		chk_flag(tx_irq, 1'b0);
		chk_flag(rx_full_flag, 1'b0);
		chk_flag(rx_edge_flag, 1'b0);
		chk_flag(rx_irq, 1'b0);
		tx_complete_flag = 1'b1;
		tx_complete_irq_enable = 1'b1;
		break_detect_flag = 1'b1;
		break_irq_enable = 1'b1;
		step(1);
		chk_flag(tx_irq, 1'b1);
		chk_flag(rx_irq, 1'b1);
		$display("disabled done");
	endtask : t_off

	// Main sequence
	initial begin
		{rst_b, receiver_on, rx_input_invert, nine_bit_mode, stop_bit_count_select,
			parity_enable, parity_odd, idle_count_type, wake_method, idle_flag_in_sleep,
			sleep_write, sleep_wdata, status_read, data_read, edge_flag_clear,
			tx_empty_flag, tx_complete_flag, break_detect_flag} = '0;
		{tx_complete_irq_enable, idle_irq_enable, edge_irq_enable, break_irq_enable} = '0;
		{overrun_irq_enable, noise_irq_enable, framing_irq_enable, parity_irq_enable} = 4'hf;
		{tx_empty_irq_enable, rx_full_irq_enable} = 2'h3;
		baud_div = 13'h0001;
		step(16);
		rst_b = 1'b1;
		receiver_on = 1'b1;
		step(8);
		t_basic();
		t_overrun();
		t_break();
		t_preload();
		t_nine_noise();
		t_sleep();
		t_off();
		complete_run();
	end
endmodule : tb_top

// ==== tb/uart_rx_chk.sv ====
`timescale 1ns/1ns
// ----------------
// Receiver checker
// ----------------
module uart_rx_chk (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       receiver_on,
	input wire logic       status_read,
	input wire logic       data_read,
	input wire logic       idle_flag_in_sleep,
	input wire logic       overrun_irq_enable,
	input wire logic       noise_irq_enable,
	input wire logic       framing_irq_enable,
	input wire logic       parity_irq_enable,
	input wire logic [8:0] rx_data,
	input wire logic       rx_full_flag,
	input wire logic       idle_flag,
	input wire logic       overrun_flag,
	input wire logic       noise_flag,
	input wire logic       framing_error_flag,
	input wire logic       parity_error_flag,
	input wire logic       rx_edge_flag,
	input wire logic       rx_sleep,
	input wire logic       err_irq
);
	logic armed_q, armed_d;                   // Status read seen while full
	logic lock_q, lock_d;                     // Idle flag spent until a load
	logic full_q;                             // Full flag one cycle back
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// Next values of the read and idle trackers
	always_comb begin
		armed_d = (armed_q || (status_read && rx_full_flag)) && !data_read;
		lock_d  = (lock_q || idle_flag) && !(rx_full_flag && !full_q);
	end
	// Tracker registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			armed_q <= 1'b0;
			lock_q  <= 1'b0;
			full_q  <= 1'b0;
		end else begin
			armed_q <= armed_d;
			lock_q  <= lock_d;
			full_q  <= rx_full_flag;
		end
	end
	AST_LOAD_ON: assert property ($rose(rx_full_flag) || $rose(rx_edge_flag) |-> $past(receiver_on))
		else $error("Receiver acted while disabled");
	AST_FE_BLOCK: assert property ($rose(rx_full_flag) |-> !$past(framing_error_flag))
		else $error("Load while framing flag set");
	AST_OVERRUN: assert property ($rose(overrun_flag) |-> $past(rx_full_flag) && $stable(rx_data)
		&& !$rose(noise_flag) && !$rose(parity_error_flag))
		else $error("Overrun without discard");
	AST_ERR_WITH_FULL: assert property ($rose(noise_flag) || $rose(framing_error_flag)
		|| $rose(parity_error_flag) |-> $rose(rx_full_flag))
		else $error("Error flag without load");
	AST_SLEEP_QUIET: assert property (rx_sleep && $past(rx_sleep)
		|-> !$rose(rx_full_flag) && !$rose(overrun_flag))
		else $error("Flag set while sleeping");
	AST_IDLE_WAKE: assert property ($rose(idle_flag) |-> !$past(rx_sleep) || $past(idle_flag_in_sleep))
		else $error("Idle flag set in sleep");
	AST_IDLE_REARM: assert property ($rose(idle_flag) |-> !lock_q)
		else $error("Idle flag set again before a load");
	AST_READ_CLEAR: assert property (data_read && armed_q |=> !rx_full_flag && !overrun_flag)
		else $error("Read sequence did not clear");
	AST_ERR_IRQ: assert property (err_irq == ((overrun_flag && overrun_irq_enable)
		|| (noise_flag && noise_irq_enable) || (framing_error_flag && framing_irq_enable)
		|| (parity_error_flag && parity_irq_enable)))
		else $error("Error request mismatch");
endmodule : uart_rx_chk

bind uart_receiver_wakeup_flags uart_rx_chk i_chk (.clock, .rst_b, .receiver_on, .status_read,
	.data_read, .idle_flag_in_sleep, .overrun_irq_enable, .noise_irq_enable, .framing_irq_enable,
	.parity_irq_enable, .rx_data, .rx_full_flag, .idle_flag, .overrun_flag, .noise_flag,
	.framing_error_flag, .parity_error_flag, .rx_edge_flag, .rx_sleep, .err_irq);

// ==== tb/uart_tx_model.sv ====
`timescale 1ns/1ns
// -------------------------
// Remote serial transmitter
// -------------------------
module uart_tx_model (
	input  wire logic clock,
	input  wire logic invert,                 // Line polarity at receiver
	output logic      line                    // Receive pin of the block
);
	logic level = 1'b1;                       // Logical level, idles high
	assign line = level ^ invert;
	// One frame, sixteen clocks a bit; glitch flips one clock
	task automatic send(input logic [8:0] data, input int nbits, input int nstop,
		input logic stop_val, input int glitch);
		int k;
		for (int i = 0; i < (1 + nbits + nstop) * 16; i++) begin
			@(posedge clock);
			#1;
			k = i / 16;
			level = ((k == 0) ? 1'b0 : (k <= nbits) ? data[k-1] : stop_val) ^ (i == glitch);
		end
		@(posedge clock);
		#1;
		level = 1'b1;
	endtask : send
endmodule : uart_tx_model
